/* core/ddc_pkg.sv */
package ddc_pkg;
  localparam logic [12:0] OFF_SYNC = 13'h100;
  localparam logic [12:0] OFF_FIR = 13'h102;
  localparam logic [12:0] OFF_HB = 13'h103;
  localparam logic [12:0] OFF_NCO = 13'h11D;
  localparam logic [12:0] OFF_FRQ0 = 13'h11E;
  localparam logic [12:0] OFF_FRQ1 = 13'h11F;
  localparam logic [12:0] OFF_FRQ2 = 13'h120;
  localparam logic [12:0] OFF_FRQ3 = 13'h121;
  localparam logic [12:0] OFF_PH0 = 13'h122;
  localparam logic [12:0] OFF_PH1 = 13'h123;
  localparam int B_NCO_EN = 0;
  localparam int B_DITH = 1;
  localparam int B_NSYNC = 3;
  localparam int B_NONCE = 4;
  localparam int B_HSYNC = 5;
  localparam int B_HONCE = 6;
  localparam int B_FIR_EN = 0;
  localparam int B_HPASS = 1;
  localparam int B_REV = 2;
  localparam int B_DPH = 3;
  localparam int B_NARM = 0;
  localparam int B_HARM = 1;
  localparam int B_OVF = 7;
  localparam logic [7:0] SYNC_CFG_MASK = 8'h78;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [5:0] QTR = 6'h10;
  localparam logic [1:0] ROT_0 = 2'h0;
  localparam logic [1:0] ROT_1 = 2'h1;
  localparam logic [1:0] ROT_2 = 2'h2;
  localparam int HB_TAPS = 19;
  localparam int HB_MID = 9;
  localparam int HB_NZ = 5;
  localparam int FIR_TAPS = 66;
  localparam int HB_SH = 20;
  localparam int FIR_SH = 21;
  localparam int MIX_SH = 9;
  localparam int IQ_BIT = 32;
  localparam int OUT_W = 33;
  localparam int FIFO_DEPTH = 4;
  localparam logic [15:0][12:0] SIN_TAB = {
    13'd4089, 13'd4050, 13'd3971, 13'd3855, 13'd3701, 13'd3512, 13'd3288, 13'd3033,
    13'd2749, 13'd2439, 13'd2105, 13'd1750, 13'd1379, 13'd995, 13'd601, 13'd201};
  localparam logic [19:0] HB_CTR = 20'd524287;
  localparam logic [4:0][19:0] HB_C = {
    20'd321584, -20'sd79170, 20'd25080, -20'sd6189, 20'd844};
  localparam logic [32:0][20:0] FIR_C = {
    21'd922060, 21'd337056, -21'sd161248, -21'sd152696, 21'd74264, 21'd98830,
    -21'sd40300, -21'sd71611, 21'd21818, 21'd53608, -21'sd11147, -21'sd41019,
    21'd3976, 21'd30748, -21'sd48, -21'sd23200, -21'sd2818, 21'd16484,
    21'd3650, -21'sd11914, -21'sd4511, 21'd7513, 21'd3788, -21'sd5150,
    -21'sd3867, 21'd2388, 21'd2476, -21'sd1750, -21'sd2661, 21'd96,
    21'd1950, 21'd1431, 21'd383};
endpackage : ddc_pkg

/* core/ddc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// Depth must be a power of two; pointers wrap freely
module ddc_fifo #(
  parameter int DW = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DW-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [DW-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } ddc_fifo_st_t;

  ddc_fifo_st_t q, d;
  logic wr, rd;

  assign in_ready = q.cnt != (AW+1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  always_comb begin
    d = q;
    if (wr) begin
      d.mem[q.wp] = in_data;
      d.wp = AW'(q.wp + 1'b1);
    end
    if (rd) begin
      d.rp = AW'(q.rp + 1'b1);
    end
    d.cnt = q.cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : ddc_fifo
`default_nettype wire

/* core/ddc_core.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Oscillator enable bit clear bypasses mixing
// - One oscillator mixes both channels to I/Q
// - Frequency word built from four byte registers
// - Frequency word is two's complement clock fraction
// - Oscillator sync on every pulse or once
// - Accepted sync restarts phase from offset
// - Sixteen-bit phase offset added to accumulator
// - Offset scales as 2^16 times degrees/360
// - Dither enable bit in oscillator control
// - Dither randomises sine/cosine amplitude rounding
// - Half-band decimates each path by two
// - Symmetric 19-tap polyphase, zero taps skipped
// - Fixed half-band coefficient values and centre
// - Half-band always in path, never bypassed
// - Response bit selects high-pass or low-pass
// - Spectral reversal bit for even zones
// - Decimation phase picks first or second sample
// - Fixed translator shifts output to rate/8
// - Fixed FIR sharpens roll-off, removes images
// - FIR enable bit zero bypasses FIR
// - Half-band sync every pulse or once
// - Translator off with oscillator enabled gives interleaved I and Q
module ddc_core
  import ddc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [12:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Converter samples, two's complement
  input wire logic [13:0] adc_a,
  input wire logic [13:0] adc_b,
  // Sync pin and translator select
  input wire logic sync_in,
  input wire logic shift_en,
  // Output stream
  output logic out_valid,
  input wire logic out_ready,
  output logic [OUT_W-1:0] out_data,
  output logic fifo_ovf
);

  typedef struct packed {
    logic [31:0] freq;
    logic [15:0] poff;
    logic [7:0] r_nco;
    logic [7:0] r_sync;
    logic [7:0] r_fir;
    logic [7:0] r_hb;
    logic n_arm;
    logic h_arm;
    logic [2:0] sy;
    logic sy_lvl;
    logic [31:0] acc;
    logic [15:0] lfsr;
    logic [3:0][HB_TAPS-1:0][15:0] hb;
    logic dph;
    logic rph;
    logic v1;
    logic [3:0][15:0] hbo;
    logic [3:0][FIR_TAPS-1:0][15:0] fir;
    logic v2;
    logic [1:0] rot;
    logic push;
    logic pend;
    logic [OUT_W-1:0] word;
    logic [OUT_W-1:0] qword;
    logic [7:0] rdata;
    logic ovf;
  } ddc_st_t;

  ddc_st_t q, d;

  logic sy_ok, sy_rise, n_sync, h_sync, wr_sync, rd_sync, f_rdy, dith;
  logic [15:0] ph;
  logic signed [12:0] sinv, cosv;
  logic signed [26:0] pai, paq, pbi, pbq;
  logic [3:0][15:0] mix;
  logic [3:0][15:0] y;
  logic signed [39:0] hs;
  logic signed [47:0] fs;
  logic signed [16:0] pair;

  // Quarter-wave table with one spare LSB so dither rounds it
  function automatic logic signed [12:0] sin_lut(input logic [5:0] p, input logic dz);
    logic [3:0] i;
    logic [13:0] a;
    logic signed [12:0] v;
    i = p[4] ? ~p[3:0] : p[3:0];
    a = {1'b0, SIN_TAB[i]} + {13'h0000, dz};
    v = $signed({1'b0, a[12:1]});
    // Top bit gives the sign, next bit mirrors the quarter
    sin_lut = p[5] ? -v : v;
  endfunction : sin_lut

  // Sync pin: level moves only when stages two and three agree
  assign sy_ok = q.sy[1] == q.sy[2];
  assign sy_rise = sy_ok & q.sy[1] & ~q.sy_lvl;
  assign wr_sync = reg_wr_en & (reg_addr == OFF_SYNC);
  assign rd_sync = reg_rd_en & (reg_addr == OFF_SYNC);
  assign n_sync = sy_rise & q.r_sync[B_NSYNC] & (~q.r_sync[B_NONCE] | q.n_arm);
  assign h_sync = sy_rise & q.r_sync[B_HSYNC] & (~q.r_sync[B_HONCE] | q.h_arm);

  // Oscillator lookup
  assign ph = q.acc[31:16] + q.poff;
  assign dith = q.r_nco[B_DITH];
  assign sinv = sin_lut(ph[15:10], dith & q.lfsr[0]);
  assign cosv = sin_lut(ph[15:10] + QTR, dith & q.lfsr[1]);

  // Shared oscillator, both channels mixed against the same phase
  assign pai = $signed(adc_a) * cosv;
  assign paq = -($signed(adc_a) * sinv);
  assign pbi = $signed(adc_b) * cosv;
  assign pbq = -($signed(adc_b) * sinv);
  assign mix[0] = q.r_nco[B_NCO_EN] ? pai[MIX_SH +: 16] : {adc_a, 2'b00};
  assign mix[1] = q.r_nco[B_NCO_EN] ? paq[MIX_SH +: 16] : 16'h0000;
  assign mix[2] = q.r_nco[B_NCO_EN] ? pbi[MIX_SH +: 16] : {adc_b, 2'b00};
  assign mix[3] = q.r_nco[B_NCO_EN] ? pbq[MIX_SH +: 16] : 16'h0000;

  always_comb begin
    d = q;
    hs = '0;
    fs = '0;
    pair = '0;
    y = '0;

    // Register writes
    if (reg_wr_en) begin
      case (reg_addr)
        OFF_SYNC: d.r_sync = reg_wdata;
        OFF_FIR: d.r_fir = reg_wdata;
        OFF_HB: d.r_hb = reg_wdata;
        OFF_NCO: d.r_nco = reg_wdata;
        OFF_FRQ0: d.freq[7:0] = reg_wdata;
        OFF_FRQ1: d.freq[15:8] = reg_wdata;
        OFF_FRQ2: d.freq[23:16] = reg_wdata;
        OFF_FRQ3: d.freq[31:24] = reg_wdata;
        OFF_PH0: d.poff[7:0] = reg_wdata;
        OFF_PH1: d.poff[15:8] = reg_wdata;
        default: begin
        end
      endcase
    end

    // Register reads, status folded into the sync register
    if (reg_rd_en) begin
      case (reg_addr)
        OFF_SYNC: begin
          d.rdata = q.r_sync & SYNC_CFG_MASK;
          d.rdata[B_NARM] = q.n_arm;
          d.rdata[B_HARM] = q.h_arm;
          d.rdata[B_OVF] = q.ovf;
        end
        OFF_FIR: d.rdata = q.r_fir;
        OFF_HB: d.rdata = q.r_hb;
        OFF_NCO: d.rdata = q.r_nco;
        OFF_FRQ0: d.rdata = q.freq[7:0];
        OFF_FRQ1: d.rdata = q.freq[15:8];
        OFF_FRQ2: d.rdata = q.freq[23:16];
        OFF_FRQ3: d.rdata = q.freq[31:24];
        OFF_PH0: d.rdata = q.poff[7:0];
        OFF_PH1: d.rdata = q.poff[15:8];
        default: d.rdata = RD_NONE;
      endcase
    end

    // Sync capture and one-shot arming; a write re-arms even if a sync lands
    d.sy = {q.sy[1:0], sync_in};
    if (sy_ok) begin
      d.sy_lvl = q.sy[1];
    end
    if (n_sync) begin
      d.n_arm = 1'b0;
    end
    if (h_sync) begin
      d.h_arm = 1'b0;
    end
    if (wr_sync) begin
      d.n_arm = 1'b1;
      d.h_arm = 1'b1;
    end

    // Phase accumulator wraps modulo 2^32, so the word is signed frequency
    d.acc = n_sync ? '0 : q.acc + q.freq;
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};

    // Half-band: only the five nonzero pairs and the centre are multiplied
    for (int p = 0; p < 4; p++) begin
      d.hb[p] = {q.hb[p][HB_TAPS-2:0], mix[p]};
      hs = $signed(q.hb[p][HB_MID]) * $signed(HB_CTR);
      // High-pass flips only the centre tap; pairs stay as they are
      if (q.r_hb[B_HPASS]) begin
        hs = -hs;
      end
      for (int k = 0; k < HB_NZ; k++) begin
        pair = $signed(q.hb[p][2*k]) + $signed(q.hb[p][HB_TAPS-1-2*k]);
        hs = hs + pair * $signed(HB_C[k]);
      end
      if (q.r_hb[B_REV] & q.rph) begin
        hs = -hs;
      end
      if (q.dph) begin
        d.hbo[p] = hs[HB_SH +: 16];
      end
    end
    d.v1 = q.dph;
    // Sync reloads the programmed phase, otherwise it alternates
    d.dph = h_sync ? q.r_hb[B_DPH] : ~q.dph;
    if (h_sync) begin
      d.rph = 1'b0;
    end else if (q.dph) begin
      d.rph = ~q.rph;
    end

    // Fixed FIR at the decimated rate; bypass keeps the same latency
    d.v2 = q.v1;
    for (int p = 0; p < 4; p++) begin
      if (q.v1) begin
        d.fir[p] = {q.fir[p][FIR_TAPS-2:0], q.hbo[p]};
      end
      fs = '0;
      for (int k = 0; k < FIR_TAPS/2; k++) begin
        pair = $signed(q.fir[p][k]) + $signed(q.fir[p][FIR_TAPS-1-k]);
        fs = fs + pair * $signed(FIR_C[k]);
      end
      y[p] = q.r_fir[B_FIR_EN] ? fs[FIR_SH +: 16] : q.fir[p][0];
    end

    // Output stage; the quadrature word goes out the cycle after in-phase
    d.push = 1'b0;
    if (q.pend) begin
      d.push = 1'b1;
      d.word = q.qword;
      d.pend = 1'b0;
    end else if (q.v2) begin
      d.push = 1'b1;
      if (shift_en) begin
        d.rot = q.rot + 2'h1;
        case (q.rot)
          ROT_0: d.word = {1'b0, y[2], y[0]};
          ROT_1: d.word = {1'b0, -y[3], -y[1]};
          ROT_2: d.word = {1'b0, -y[2], -y[0]};
          default: d.word = {1'b0, y[3], y[1]};
        endcase
      end else begin
        d.word = {1'b0, y[2], y[0]};
        d.qword = {1'b1, y[3], y[1]};
        d.pend = q.r_nco[B_NCO_EN];
      end
    end

    // Stream cannot stall the converter, so a full buffer drops and flags
    if (rd_sync) begin
      d.ovf = 1'b0;
    end
    if (q.push & ~f_rdy) begin
      d.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      // All-zero LFSR would lock up and freeze the dither
      q.lfsr <= LFSR_SEED;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign fifo_ovf = q.ovf;

  ddc_fifo #(
    .DW(OUT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(q.push),
    .in_ready(f_rdy),
    .in_data(q.word),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // Checks are off while reset is held
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  a_nco_bypass: assert property (!q.r_nco[B_NCO_EN] |=> q.hb[1][0] == '0 && q.hb[0][0] == {$past(adc_a), 2'b00})
    else $error("bypassed oscillator altered samples");
  a_acc_step: assert property (!n_sync |=> q.acc == $past(q.acc) + $past(q.freq))
    else $error("accumulator did not step by frequency word");
  a_sync_restart: assert property (n_sync |=> q.acc == '0)
    else $error("accumulator not restarted on sync");
  a_once_disarm: assert property (n_sync && q.r_sync[B_NONCE] && !wr_sync |=> !q.n_arm)
    else $error("one-shot oscillator sync stayed armed");
  a_hb_disarm: assert property (h_sync && q.r_sync[B_HONCE] && !wr_sync |=> !q.h_arm)
    else $error("one-shot filter sync stayed armed");
  a_freq_byte: assert property (reg_wr_en && reg_addr == OFF_FRQ3 |=> q.freq[31:24] == $past(reg_wdata))
    else $error("frequency top byte not written");
  a_dec_rate: assert property (!h_sync |=> q.dph != $past(q.dph))
    else $error("decimation phase did not alternate");
  a_dec_phase: assert property (h_sync |=> q.dph == $past(q.r_hb[B_DPH]) ##1 q.v1 == $past(q.dph))
    else $error("decimation phase wrong after sync");
  a_iq_pair: assert property (q.v2 && !q.pend && !shift_en && q.r_nco[B_NCO_EN]
    |=> q.push && !q.word[IQ_BIT] ##1 q.push && q.word[IQ_BIT])
    else $error("interleaved I then Q not produced");
  a_rot_step: assert property (q.v2 && !q.pend && shift_en |=> q.rot == $past(q.rot) + 2'h1)
    else $error("translator rotation did not advance");
  a_fir_bypass: assert property (q.v2 && !q.pend && !q.r_fir[B_FIR_EN] && !shift_en
    |=> q.word[15:0] == $past(q.fir[0][0]))
    else $error("bypassed FIR altered data");

  // Register bytes land one cycle after the write
  a_freq_low: assert property (reg_wr_en && reg_addr == OFF_FRQ0 |=> q.freq[7:0] == $past(reg_wdata))
    else $error("frequency low byte not written");
  a_poff_high: assert property (reg_wr_en && reg_addr == OFF_PH1 |=> q.poff[15:8] == $past(reg_wdata))
    else $error("phase offset high byte not written");
  a_ctrl_write: assert property (reg_wr_en && reg_addr == OFF_NCO |=> q.r_nco == $past(reg_wdata))
    else $error("oscillator control not written");
  a_resp_write: assert property (reg_wr_en && reg_addr == OFF_HB |=> q.r_hb == $past(reg_wdata))
    else $error("filter control not written");
  a_rev_toggle: assert property (q.dph && !h_sync |=> q.rph != $past(q.rph))
    else $error("reversal sign did not alternate");
  a_nco_mix: assert property (q.r_nco[B_NCO_EN] |=> q.hb[0][0] == $past(pai[MIX_SH +: 16]))
    else $error("oscillator product not fed to filter");
  a_real_only: assert property (q.v2 && !q.pend && (shift_en || !q.r_nco[B_NCO_EN])
    |=> q.push && !q.pend)
    else $error("real output produced a quadrature word");
endmodule : ddc_core
`default_nettype wire

/* verif/ddc_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module ddc_partner (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Bench controls
  input wire logic stall,
  input wire logic sync_req,
  input wire logic [13:0] smp_a,
  input wire logic [13:0] smp_b,
  // Converter side
  output logic [13:0] adc_a,
  output logic [13:0] adc_b,
  output logic sync_in,
  // Formatter side
  output logic out_ready
);
  logic [2:0] sync_cnt_q;
  // Sync held four clocks, longer than the pin filter needs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_cnt_q <= 3'h0;
      out_ready <= 1'b0;
    end else begin
      out_ready <= ~stall;
      if (sync_req) begin
        sync_cnt_q <= 3'h4;
      end else if (sync_cnt_q != 3'h0) begin
        sync_cnt_q <= sync_cnt_q - 3'h1;
      end
    end
  end
  // Converter never pauses; one sample every clock
  always_ff @(posedge clk_sys) begin
    adc_a <= smp_a;
    adc_b <= smp_b;
  end
  assign sync_in = (sync_cnt_q != 3'h0);
endmodule : ddc_partner
`default_nettype wire

/* verif/tb_ddc_core.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_ddc_core
  import ddc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [12:0] reg_addr = 13'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic shift_en = 1'b0;
  logic stall = 1'b0;
  logic sync_req = 1'b0;
  logic [13:0] smp_a = 14'h0;
  logic [13:0] smp_b = 14'h0;
  logic [7:0] reg_rdata;
  logic [13:0] adc_a;
  logic [13:0] adc_b;
  logic sync_in;
  logic out_valid;
  logic out_ready;
  logic [OUT_W-1:0] out_data;
  logic fifo_ovf;
  logic rd_seen = 1'b0;
  logic [7:0] rd_q[$];
  logic [32:0] out_q[$];
  logic [12:0] regs [6] = '{OFF_FRQ0, OFF_FRQ1, OFF_FRQ2, OFF_FRQ3, OFF_PH0, OFF_PH1};
  logic [7:0] cfg [2] = '{8'h78, 8'h28};
  logic [7:0] d;
  int fail_count = 0;
  int check_count = 0;
  int n_w = 0;
  int n_q = 0;
  int n_neg = 0;
  int xa, xb, w, q, n;
  int gh = 0;
  int gf = 0;

  always #2.5 clk_sys = ~clk_sys;

  ddc_core u_ddc_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .adc_a(adc_a), .adc_b(adc_b),
    .sync_in(sync_in), .shift_en(shift_en), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .fifo_ovf(fifo_ovf));
  ddc_partner u_ddc_partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .stall(stall), .sync_req(sync_req),
    .smp_a(smp_a), .smp_b(smp_b), .adc_a(adc_a), .adc_b(adc_b), .sync_in(sync_in), .out_ready(out_ready));

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Extra idle edge keeps back-to-back calls from reassigning the strobe
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    @(posedge clk_sys);
  endtask : rd

  task automatic span(output int dw, output int dq, output int dn);
    int w0, q0, n0;
    repeat (60) @(posedge clk_sys);
    w0 = n_w;
    q0 = n_q;
    n0 = n_neg;
    repeat (100) @(posedge clk_sys);
    dw = n_w - w0;
    dq = n_q - q0;
    dn = n_neg - n0;
  endtask : span

  // Steady DC response; mode 1 high-pass, mode 2 adds the fixed FIR
  function automatic logic [15:0] filt(input int x, input int m);
    longint h;
    h = longint'(4 * x) * (m == 1 ? gh - 2 * int'(HB_CTR) : gh);
    h = longint'($signed(16'(h >>> 20)));
    if (m == 2) h = (h * gf) >>> 21;
    return 16'(h);
  endfunction : filt

  always @(posedge clk_sys) begin
    rd_seen <= reg_rd_en;
    if (rd_seen && rd_q.size() > 0) check({25'h0, reg_rdata}, {25'h0, rd_q.pop_front()});
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      n_w <= n_w + 1;
      n_q <= n_q + int'(out_data[32]);
      n_neg <= n_neg + int'(out_data[15]);
      if (out_q.size() > 0) check(out_data, out_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    void'($urandom(60));
    xa = $urandom_range(2000, 1);
    xb = $urandom_range(2000, 1);
    smp_a <= 14'(xa);
    smp_b <= 14'(xb);
    for (int i = 0; i < HB_NZ; i++) gh += 2 * int'($signed(HB_C[i]));
    gh += int'(HB_CTR);
    for (int i = 0; i < FIR_TAPS / 2; i++) gf += 2 * int'($signed(FIR_C[i]));
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    foreach (regs[i]) rd(regs[i], 8'h00);
    foreach (regs[i]) begin
      d = 8'($urandom);
      wr(regs[i], d);
      rd(regs[i], d);
    end
    wr(13'h101, 8'hA5);
    rd(13'h101, RD_NONE);
    $display("test registers done");
    stall <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check({32'h0, fifo_ovf}, 33'h1);
    stall <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(OFF_SYNC, 8'h80);
    rd(OFF_SYNC, 8'h00);
    $display("test buffer done");
    for (int m = 0; m < 3; m++) begin
      wr(OFF_HB, m == 1 ? 8'h02 : 8'h00);
      wr(OFF_FIR, m == 2 ? 8'h01 : 8'h00);
      repeat (300) @(posedge clk_sys);
      repeat (4) out_q.push_back({1'b0, filt(xb, m), filt(xa, m)});
      repeat (12) @(posedge clk_sys);
      check(33'(out_q.size()), 33'h0);
    end
    $display("test filter modes done");
    wr(OFF_FIR, 8'h00);
    wr(OFF_HB, 8'h04);
    span(w, q, n);
    check(33'(n), 33'd25);
    check(33'(w), 33'd50);
    wr(OFF_HB, 8'h00);
    wr(OFF_NCO, 8'h03);
    span(w, q, n);
    check(33'(w), 33'd100);
    check(33'(q), 33'd50);
    shift_en <= 1'b1;
    span(w, q, n);
    check(33'(w), 33'd50);
    $display("test stream rates done");
    wr(OFF_HB, 8'h08);
    foreach (cfg[i]) begin
      wr(OFF_SYNC, cfg[i]);
      rd(OFF_SYNC, cfg[i] | 8'h03);
      sync_req <= 1'b1;
      @(posedge clk_sys);
      sync_req <= 1'b0;
      repeat (12) @(posedge clk_sys);
      rd(OFF_SYNC, cfg[i]);
    end
    $display("test sync done");
    repeat (4) @(posedge clk_sys);
    wrap_up();
  end
endmodule : tb_ddc_core
`default_nettype wire
